// >>> design/fdsk_dl_core.sv
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module fdsk_dl_core
  import fdsk_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  dl_done,
  fdsk_wr_if.core    rif,
  output logic       prg_pick,
  output logic       ers_pick,
  output logic [7:0] key,
  output logic       dl_req,
  output logic       prog_enable
);
  // ****************************************************************
  // register state
  // ****************************************************************
  logic       prg_q, prg_d;
  logic       ers_q, ers_d;
  logic [7:0] key_q, key_d;
  logic       req_q, req_d;
  logic       wr_prg, wr_ers, wr_key, wr_req;
  logic       req_set;

  always_comb
  begin
    wr_prg = rif.wr_en && rif.wr_addr == FDSK_OFS_PRG_SEL;
    wr_ers = rif.wr_en && rif.wr_addr == FDSK_OFS_ERS_SEL;
    wr_key = rif.wr_en && rif.wr_addr == FDSK_OFS_KEY;
    wr_req = rif.wr_en && rif.wr_addr == FDSK_OFS_REQ;
    // request may only be set with download key; zero write ignored
    req_set = wr_req && rif.wr_data[FDSK_REQ_BIT]
              && key_q == FDSK_KEY_DOWNLOAD;
    prg_d = prg_q;
    ers_d = ers_q;
    key_d = key_q;
    req_d = req_q;
    // completion clears first, so a write in the same cycle wins
    if (dl_done && req_q)
    begin
      prg_d = 1'b0;
      ers_d = 1'b0;
      req_d = 1'b0;
    end
    if (wr_prg)
      prg_d = rif.wr_data[FDSK_PICK_BIT];
    if (wr_ers)
      ers_d = rif.wr_data[FDSK_PICK_BIT];
    if (wr_key)
      key_d = rif.wr_data;
    if (req_set)
      req_d = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prg_q <= FDSK_SEL_RESET[0];
      ers_q <= FDSK_SEL_RESET[0];
      key_q <= FDSK_KEY_RESET;
      req_q <= 1'b0;
    end
    else
    begin
      prg_q <= prg_d;
      ers_q <= ers_d;
      key_q <= key_d;
      req_q <= req_d;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb
  begin
    rif.rd_data = 32'h0000_0000;
    // next values: a read right behind a write sees the written data
    unique case (rif.rd_addr)
      FDSK_OFS_PRG_SEL: rif.rd_data = {31'h0, prg_d};
      FDSK_OFS_ERS_SEL: rif.rd_data = {31'h0, ers_d};
      FDSK_OFS_KEY:     rif.rd_data = {24'h0, key_d};
      FDSK_OFS_REQ:     rif.rd_data = {31'h0, req_d};
      FDSK_OFS_STATUS:
        rif.rd_data = {30'h0, key_d == FDSK_KEY_PROGRAM, req_d};
      default:          rif.rd_data = 32'h0000_0000;
    endcase
  end

  assign prg_pick    = prg_q;
  assign ers_pick    = ers_q;
  assign key         = key_q;
  assign dl_req      = req_q;
  assign prog_enable = key_q == FDSK_KEY_PROGRAM;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_req_needs_key: assert property (
    $rose(req_q) |-> $past(key_q) == FDSK_KEY_DOWNLOAD)
    else $error("download request set without download key");
  chk_pick_cleared: assert property (
    dl_done && req_q |=> (!prg_q || $past(wr_prg))
      && (!ers_q || $past(wr_ers)) && (!req_q || $past(req_set)))
    else $error("pick bits not cleared at download completion");
  chk_prog_gate: assert property (
    $rose(prog_enable) |-> $past(wr_key)
      && $past(rif.wr_data) == FDSK_KEY_PROGRAM)
    else $error("program enable raised without program key write");
  chk_key_holds: assert property (
    !wr_key |=> $stable(key_q))
    else $error("key changed without a write");
  chk_key_write: assert property (
    wr_key |=> key_q == $past(rif.wr_data))
    else $error("key write not stored");
  chk_prg_write: assert property (
    wr_prg |=> prg_q == $past(rif.wr_data[0]))
    else $error("program pick write not stored");
  chk_ers_write: assert property (
    wr_ers |=> ers_q == $past(rif.wr_data[0]))
    else $error("erase pick write not stored");
  chk_sel_reserved: assert property (
    rif.rd_addr == FDSK_OFS_PRG_SEL || rif.rd_addr == FDSK_OFS_ERS_SEL
    |-> rif.rd_data[31:1] == 31'h0)
    else $error("reserved select bits read nonzero");
  chk_req_key_bad: assert property (
    wr_req && !req_q && key_q != FDSK_KEY_DOWNLOAD |=> !req_q)
    else $error("request set with wrong key");
  cov_download: cover property (
    $rose(req_q) ##[1:50] $fell(req_q));
  cov_prog_en: cover property (
    $rose(prog_enable));
  cov_refused: cover property (
    wr_req && key_q != FDSK_KEY_DOWNLOAD);
  cov_write_wins: cover property (
    dl_done && req_q && wr_prg);
endmodule
`default_nettype wire

// >>> design/fdsk_pkg.sv
// Notes on behaviour
// - program select bits 7..1 read zero; software writes zero
// - erase select bits 7..1 read zero; software writes zero
// - program select bit 0 is read/write; one picks programming routine
// - erase select bit 0 is read/write; one picks erase routine
// - hardware clears both pick bits when the download completes; a pick write in that same cycle wins over the clear
// - download request bit sets only while key holds A5
// - programming or erasing permitted only while key holds 5A
// - key and both select registers reset to zero
// - request copies selected routine into RAM; cleared on completion
package fdsk_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  FDSK_OFS_PRG_SEL  = 8'h00;
  localparam logic [7:0]  FDSK_OFS_ERS_SEL  = 8'h04;
  localparam logic [7:0]  FDSK_OFS_KEY      = 8'h08;
  localparam logic [7:0]  FDSK_OFS_REQ      = 8'h0C;
  localparam logic [7:0]  FDSK_OFS_STATUS   = 8'h10;
  localparam logic [7:0]  FDSK_SEL_RESET    = 8'h00;
  localparam logic [7:0]  FDSK_KEY_RESET    = 8'h00;
  localparam logic [7:0]  FDSK_KEY_DOWNLOAD = 8'hA5;
  localparam logic [7:0]  FDSK_KEY_PROGRAM  = 8'h5A;
  localparam int          FDSK_PICK_BIT     = 0;
  localparam int          FDSK_REQ_BIT      = 0;
  localparam logic [1:0]  FDSK_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  FDSK_HSIZE_WORD   = 3'h2;
endpackage

// >>> design/fdsk_wr_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries one decoded register write from bus slave to core
interface fdsk_wr_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  modport slave (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
  modport core  (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> design/fdsk_ahb_slave.sv
`timescale 1ns/10ps
`default_nettype none
module fdsk_ahb_slave
  import fdsk_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  fdsk_wr_if.slave         rif
);
  // ****************************************************************
  // address phase capture
  // ****************************************************************
  logic       wr_pend_q;
  logic       wr_pend_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic       take;

  // sizes other than word are still taken; only low byte matters
  assign take = hsel && hready && htrans == FDSK_HTRANS_NONSEQ;

  always_comb
  begin
    wr_pend_d = take && hwrite;
    addr_d    = take ? haddr[7:0] : addr_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
    end
  end

  // zero wait states, always OKAY
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign rif.wr_en   = wr_pend_q;
  assign rif.wr_addr = addr_q;
  assign rif.wr_data = hwdata[7:0];
  assign rif.rd_addr = haddr[7:0];

  // read data registered at the address phase, shown in data phase
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  always_comb
  begin
    hrdata_d = (take && !hwrite) ? rif.rd_data : hrdata_q;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_q <= 32'h0000_0000;
    else
      hrdata_q <= hrdata_d;
  end
  assign hrdata = hrdata_q;
endmodule
`default_nettype wire

// >>> design/fdsk_top.sv
`timescale 1ns/10ps
`default_nettype none
module fdsk_top
  import fdsk_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        DL_DONE,
  output logic             DL_REQ,
  output logic             PRG_PICK,
  output logic             ERS_PICK,
  output logic             PROG_ENABLE
);
  fdsk_wr_if rif ();

  fdsk_ahb_slave u_slv (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hsize     (HSIZE),
    .hready    (HREADY),
    .hwdata    (HWDATA),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .rif       (rif)
  );

  fdsk_dl_core u_core (
    .clk         (REF_CLK),
    .rst_n       (RESETN),
    .dl_done     (DL_DONE),
    .rif         (rif),
    .prg_pick    (PRG_PICK),
    .ers_pick    (ERS_PICK),
    .key         (),
    .dl_req      (DL_REQ),
    .prog_enable (PROG_ENABLE)
  );
endmodule
`default_nettype wire

// >>> dv/flash_download_select_and_key_tb.sv
`timescale 1ns/10ps
`default_nettype none
module flash_download_select_and_key_tb
  import fdsk_pkg::*;
;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  logic        REF_CLK = 1'b0;
  logic        RESETN  = 1'b0;
  logic        HSEL    = 1'b0;
  logic [31:0] HADDR   = 32'h00000000;
  logic [1:0]  HTRANS  = 2'h0;
  logic        HWRITE  = 1'b0;
  logic [31:0] HWDATA  = 32'h00000000;
  logic        DL_DONE = 1'b0;
  logic        HREADY;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        DL_REQ;
  logic        PRG_PICK;
  logic        ERS_PICK;
  logic        PROG_ENABLE;
  int          fails = 0;
  int          checks_done = 0;
  logic [7:0]  keys [7] = '{8'h00, 8'hA4, 8'hA7, 8'h5B, 8'h25, 8'hFF, 8'h5A};
  // single slave: its ready is the bus ready
  assign HREADY = HREADYOUT;
  always #2.5 REF_CLK = ~REF_CLK;
  fdsk_top DUT (.REF_CLK(REF_CLK), .RESETN(RESETN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(FDSK_HSIZE_WORD),
    .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DL_DONE(DL_DONE), .DL_REQ(DL_REQ),
    .PRG_PICK(PRG_PICK), .ERS_PICK(ERS_PICK), .PROG_ENABLE(PROG_ENABLE));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one single transfer; no wait count assumed, watchdog ends a hang
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge REF_CLK);
    HSEL   <= 1'b1;
    HTRANS <= FDSK_HTRANS_NONSEQ;
    HADDR  <= {24'h000000, a};
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    check("hresp", {31'h0, HRESP}, 32'h00000000);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(a, 1'b1, d, rd);
  endtask
  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
    logic [31:0] rd;
    bus(a, 1'b0, 32'h00000000, rd);
    check(name, rd, exp);
  endtask
  // order: request, program pick, erase pick, program enable
  task automatic pins(input logic [3:0] exp);
    check("pins", {28'h0, DL_REQ, PRG_PICK, ERS_PICK, PROG_ENABLE},
          {28'h0, exp});
  endtask
  task automatic done_pulse();
    @(posedge REF_CLK);
    DL_DONE <= 1'b1;
    @(posedge REF_CLK);
    DL_DONE <= 1'b0;
    #1;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial
  begin
    #20000;
    fails++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge REF_CLK);
    RESETN <= 1'b1;
    pins(4'h0);
    rchk("prg_sel", FDSK_OFS_PRG_SEL, 32'h00000000);
    rchk("ers_sel", FDSK_OFS_ERS_SEL, 32'h00000000);
    rchk("key", FDSK_OFS_KEY, 32'h00000000);
    wr(FDSK_OFS_PRG_SEL, 32'h00000001);
    rchk("prg_sel", FDSK_OFS_PRG_SEL, 32'h00000001);
    wr(FDSK_OFS_ERS_SEL, 32'h00000000);
    rchk("ers_sel", FDSK_OFS_ERS_SEL, 32'h00000000);
    wr(FDSK_OFS_ERS_SEL, 32'h00000001);
    rchk("ers_sel", FDSK_OFS_ERS_SEL, 32'h00000001);
    pins(4'h6);
    // completion without a pending request must leave picks alone
    done_pulse();
    pins(4'h6);
    foreach (keys[i])
    begin
      wr(FDSK_OFS_KEY, {24'h000000, keys[i]});
      wr(FDSK_OFS_REQ, 32'h00000001);
      pins({3'h3, keys[i] == FDSK_KEY_PROGRAM});
      rchk("key", FDSK_OFS_KEY, {24'h000000, keys[i]});
    end
    wr(FDSK_OFS_KEY, {24'h000000, FDSK_KEY_DOWNLOAD});
    wr(FDSK_OFS_REQ, 32'h00000001);
    pins(4'hE);
    rchk("status", FDSK_OFS_STATUS, 32'h00000001);
    rchk("key", FDSK_OFS_KEY, 32'h000000A5);
    done_pulse();
    pins(4'h0);
    rchk("prg_sel", FDSK_OFS_PRG_SEL, 32'h00000000);
    rchk("ers_sel", FDSK_OFS_ERS_SEL, 32'h00000000);
    wr(FDSK_OFS_KEY, {24'h000000, FDSK_KEY_PROGRAM});
    pins(4'h1);
    rchk("status", FDSK_OFS_STATUS, 32'h00000002);
    rchk("unmapped", 8'h20, 32'h00000000);
    // pick write landing in the completion cycle wins over the clear
    wr(FDSK_OFS_KEY, {24'h000000, FDSK_KEY_DOWNLOAD});
    wr(FDSK_OFS_REQ, 32'h00000001);
    fork
      wr(FDSK_OFS_PRG_SEL, 32'h00000001);
      begin
        repeat (2) @(posedge REF_CLK);
        DL_DONE <= 1'b1;
        @(posedge REF_CLK);
        DL_DONE <= 1'b0;
      end
    join
    pins(4'h4);
    // reset in mid-run clears everything again
    wr(FDSK_OFS_PRG_SEL, 32'h00000001);
    @(posedge REF_CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1;
    pins(4'h0);
    @(posedge REF_CLK);
    RESETN <= 1'b1;
    rchk("key", FDSK_OFS_KEY, 32'h00000000);
    rchk("prg_sel", FDSK_OFS_PRG_SEL, 32'h00000000);
    close_out();
  end
endmodule
`default_nettype wire
